// ### dsr_pkg.sv
package dsr_pkg;

    // =========================================================
    // Sizes
    localparam int DSR_DATA_W   = 18;
    localparam int DSR_ADDR_W   = 20;
    localparam int DSR_MEM_AW   = 4;    // Modelled array address bits (16 words), small on purpose
    localparam int DSR_BURST    = 2;

    // =========================================================
    // Reset values
    localparam logic [DSR_DATA_W-1:0] DSR_DATA_RST  = 18'h00000;
    localparam logic [DSR_ADDR_W-1:0] DSR_ADDR_RST  = 20'h00000;
    localparam logic                  DSR_SINGLE_RST = 1'b0;

    // =========================================================
    // Read output sequencer, Gray coded except the step from DSR_RD_HOLD back to DSR_RD_IDLE
    typedef enum logic [1:0] {
        DSR_RD_IDLE   = 2'b00,
        DSR_RD_SECOND = 2'b01,
        DSR_RD_HOLD   = 2'b11
    } dsr_rd_state_type;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic                  load_strobe_n;
        logic                  read_not_write;
        logic [DSR_ADDR_W-1:0] addr;
    } dsr_cmd_type;

    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
    } dsr_clk_type;

endpackage

// ### dsr_sram_front.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1 - With the load strobe low at a positive input clock rise, direction high loads a read, low a write.
// RULE2 - Inputs are captured and accesses start on the positive input clock rise, which also launches read data in single-clock mode.
// RULE3 - Write data is captured on the negative input clock rise, which also drives read data in single-clock mode.
// RULE4 - Outside single-clock mode the output clock pair times the read data driven out.
// RULE5 - The echo clock pair runs freely, following the positive output clock, or the positive input clock in single-clock mode.
// RULE6 - Holding the delay-loop disable input low switches the delay loop off, which shifts output timing.
// RULE7 - A low load strobe defines a new bus cycle and every transaction moves exactly two data words.
// RULE8 - Single-clock mode is a strap: both output clocks held high from power-on and never changed.
// RULE9 - On read deselect, pending bursts finish and the data pins float after the next positive output clock rise.
module dsr_sram_front (
    // System
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    // Clock pins, sampled in clk_sys
    input  wire dsr_pkg::dsr_clk_type           clk_pins,
    // Command pins
    input  wire dsr_pkg::dsr_cmd_type           cmd,
    // Strap
    input  wire logic                           delay_loop_disable_n,
    // Data pins
    input  wire logic [dsr_pkg::DSR_DATA_W-1:0] dq_in,
    output logic      [dsr_pkg::DSR_DATA_W-1:0] dq_out,
    output logic                                dq_oe,
    // Echo clocks
    output logic                                echo_clock,
    output logic                                echo_clock_n
);
    import dsr_pkg::*;

    // =========================================================
    // Reset release
    logic rst_meta_q, rst_sync_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // =========================================================
    // Edge detection on the clock pins
    dsr_clk_type clk_q;
    logic        strap_done_q, single_q;
    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            // All ones, so a pin that is already high at release shows no false rising edge
            clk_q        <= '1;
            strap_done_q <= 1'b0;
            single_q     <= DSR_SINGLE_RST;
        end else begin
            clk_q        <= clk_pins;
            strap_done_q <= 1'b1;
            // Strap caught once after release and held; later changes are ignored
            if (!strap_done_q) begin
                single_q <= clk_pins.c & clk_pins.c_n; // RULE8
            end
        end
    end

    wire k_rise   = clk_pins.k   & ~clk_q.k;
    wire kn_rise  = clk_pins.k_n & ~clk_q.k_n;
    wire c_rise   = clk_pins.c   & ~clk_q.c;
    wire cn_rise  = clk_pins.c_n & ~clk_q.c_n;
    wire out_pos  = single_q ? k_rise  : c_rise;   // RULE2 RULE4
    wire out_neg  = single_q ? kn_rise : cn_rise;  // RULE3 RULE4
    wire echo_src = single_q ? clk_pins.k : clk_pins.c; // RULE5
    wire load_now = k_rise & ~cmd.load_strobe_n;   // RULE7

    // =========================================================
    // Command capture
    logic                  rd_load_q, rd_ready_q, wr_load_q, wr_phase_q;
    logic [DSR_ADDR_W-1:0] rd_addr_q, rd_go_addr_q, wr_addr_q;
    logic [DSR_DATA_W-1:0] wr_word0_q;

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rd_load_q <= 1'b0;
            wr_load_q <= 1'b0;
            rd_addr_q <= DSR_ADDR_RST;
            wr_addr_q <= DSR_ADDR_RST;
        end else if (k_rise) begin
            rd_load_q <= load_now & cmd.read_not_write;   // RULE1 RULE2
            wr_load_q <= load_now & ~cmd.read_not_write;  // RULE1 RULE2
            if (load_now) begin
                rd_addr_q <= cmd.addr;
                if (!cmd.read_not_write) begin
                    wr_addr_q <= cmd.addr;
                end
            end
        end
    end

    // Read is staged one positive input clock after its load
    wire rd_arm = single_q ? (k_rise & rd_load_q) : (c_rise & rd_ready_q);
    // Single mode launches on the staging edge itself, before the staged copy is written
    wire [DSR_ADDR_W-1:0] rd_src_addr = single_q ? rd_addr_q : rd_go_addr_q; // RULE1
    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rd_ready_q   <= 1'b0;
            rd_go_addr_q <= DSR_ADDR_RST;
        end else if (k_rise && rd_load_q) begin
            rd_ready_q   <= 1'b1;
            rd_go_addr_q <= rd_addr_q;
        end else if (rd_arm) begin
            rd_ready_q   <= 1'b0;
        end
    end

    // =========================================================
    // Storage and write burst
    logic [DSR_DATA_W-1:0] mem_q [2**DSR_MEM_AW];

    function automatic logic [DSR_MEM_AW-1:0] dsr_word(input logic [DSR_ADDR_W-1:0] a,
                                                       input logic second);
        // Two-word burst toggles only the low address bit
        return {a[DSR_MEM_AW-1:1], a[0] ^ second}; // RULE7
    endfunction

    wire wr_fire = kn_rise & wr_phase_q;
    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wr_phase_q <= 1'b0;
            wr_word0_q <= DSR_DATA_RST;
        end else begin
            if (k_rise && wr_load_q) begin
                wr_word0_q <= dq_in;            // RULE2
                wr_phase_q <= 1'b1;
            end else if (wr_fire) begin
                wr_phase_q <= 1'b0;             // RULE3
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_fire) begin
            mem_q[dsr_word(wr_addr_q, 1'b0)] <= wr_word0_q;
            mem_q[dsr_word(wr_addr_q, 1'b1)] <= dq_in; // RULE3
        end
    end

    // =========================================================
    // Read output sequencer
    dsr_rd_state_type      rd_st_q, rd_st_d;
    // Burst address held per launch, so a load right behind it cannot bend the second word
    logic [DSR_ADDR_W-1:0] rd_cur_q;
    logic [DSR_DATA_W-1:0] dq_raw_q, dq_raw_d, dq_dly_q;
    logic                  oe_raw_q, oe_raw_d, oe_dly_q;
    logic                  echo_raw_q, echo_dly_q;

    always_comb begin
        rd_st_d  = rd_st_q;
        dq_raw_d = dq_raw_q;
        oe_raw_d = oe_raw_q;
        case (rd_st_q)
            DSR_RD_IDLE: begin
                if (rd_arm) begin
                    dq_raw_d = mem_q[dsr_word(rd_src_addr, 1'b0)];
                    oe_raw_d = 1'b1;
                    rd_st_d  = DSR_RD_SECOND;
                end
            end
            DSR_RD_SECOND: begin
                if (out_neg) begin
                    dq_raw_d = mem_q[dsr_word(rd_cur_q, 1'b1)]; // RULE3 RULE7
                    rd_st_d  = DSR_RD_HOLD;
                end
            end
            DSR_RD_HOLD: begin
                if (rd_arm) begin
                    dq_raw_d = mem_q[dsr_word(rd_src_addr, 1'b0)];
                    rd_st_d  = DSR_RD_SECOND;
                end else if (out_pos) begin
                    oe_raw_d = 1'b0;                // RULE9
                    rd_st_d  = DSR_RD_IDLE;
                end
            end
            default: begin
                oe_raw_d = 1'b0;
                rd_st_d  = DSR_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rd_st_q    <= DSR_RD_IDLE;
            rd_cur_q   <= DSR_ADDR_RST;
            dq_raw_q   <= DSR_DATA_RST;
            oe_raw_q   <= 1'b0;
            echo_raw_q <= 1'b0;
        end else begin
            rd_st_q    <= rd_st_d;
            dq_raw_q   <= dq_raw_d;
            oe_raw_q   <= oe_raw_d;
            echo_raw_q <= echo_src;             // RULE5
            if (rd_arm) begin
                rd_cur_q <= rd_src_addr;        // RULE7
            end
        end
    end

    // =========================================================
    // Output stage: with the delay loop off, outputs lag one extra cycle
    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            dq_dly_q     <= DSR_DATA_RST;
            oe_dly_q     <= 1'b0;
            echo_dly_q   <= 1'b0;
            dq_out       <= DSR_DATA_RST;
            dq_oe        <= 1'b0;
            echo_clock   <= 1'b0;
            echo_clock_n <= 1'b1;
        end else begin
            dq_dly_q     <= dq_raw_q;
            oe_dly_q     <= oe_raw_q;
            echo_dly_q   <= echo_raw_q;
            dq_out       <= delay_loop_disable_n ? dq_raw_q   : dq_dly_q;   // RULE6
            dq_oe        <= delay_loop_disable_n ? oe_raw_q   : oe_dly_q;   // RULE6
            echo_clock   <= delay_loop_disable_n ? echo_raw_q : echo_dly_q; // RULE6
            echo_clock_n <= delay_loop_disable_n ? ~echo_raw_q : ~echo_dly_q;
        end
    end

    // =========================================================
    // Checks
    default clocking dsr_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_q);

    sequence dsr_burst_start;
        rd_st_q == DSR_RD_SECOND && out_neg;
    endsequence

    chk_read_load: assert property (load_now && cmd.read_not_write |=> rd_load_q) // RULE1
        else $error("read load not captured");
    chk_write_load: assert property (load_now && !cmd.read_not_write |=> wr_load_q) // RULE1
        else $error("write load not captured");
    chk_start_on_k: assert property ($rose(rd_load_q) |-> $past(k_rise)) // RULE2
        else $error("access started off the input clock");
    chk_write_second: assert property (kn_rise && wr_phase_q |=> !wr_phase_q) // RULE3
        else $error("second write word not taken");
    chk_out_timing: assert property // RULE4
        (rd_st_q == DSR_RD_SECOND && $past(rd_st_q) != DSR_RD_SECOND |-> $past(out_pos))
        else $error("read launched off the output clock");
    // The echo pipeline still shows reset values for its depth after release
    chk_echo_follow: assert property // RULE5
        ($past(rst_sync_q, 2) && $past(delay_loop_disable_n)
         |-> echo_clock == $past(echo_src, 2))
        else $error("echo clock not following source");
    chk_dll_off_lag: assert property // RULE6
        ($past(rst_sync_q, 3) && !$past(delay_loop_disable_n)
         |-> echo_clock == $past(echo_src, 3))
        else $error("delay loop off timing wrong");
    chk_burst_two: assert property (dsr_burst_start |=> rd_st_q == DSR_RD_HOLD) // RULE7
        else $error("burst did not take two words");
    chk_tristate_tail: assert property // RULE9
        (rd_st_q == DSR_RD_HOLD && out_pos && !rd_arm |=> !oe_raw_q ##1 rd_st_q == DSR_RD_IDLE)
        else $error("data pins not released");

endmodule // dsr_sram_front

// ### dsr_ctrl_model.sv
`timescale 1ns/100ps
module dsr_ctrl_model (
    // System
    input  wire logic             clk_sys,
    // Strap request
    input  wire logic             single_mode,
    // Clock pins and their phase
    output dsr_pkg::dsr_clk_type  clk_pins,
    output logic [1:0]            phase
);
    import dsr_pkg::*;

    // =========================================================
    // Input clock pair, four system cycles a period
    logic k_lvl;
    initial phase = 2'h0;
    always @(negedge clk_sys) begin
        phase <= phase + 2'h1;
    end
    assign k_lvl = (phase < 2'h2);

    // =========================================================
    // Output pair with zero skew to the input pair, or both held high as the strap
    assign clk_pins = '{k: k_lvl, k_n: ~k_lvl,
                        c: single_mode | k_lvl, c_n: single_mode | ~k_lvl};
endmodule // dsr_ctrl_model

// ### test_dual_edge_sram_clock_access_pins.sv
`timescale 1ns/100ps
module test_dual_edge_sram_clock_access_pins;
    import dsr_pkg::*;

    logic                  clk_sys;
    logic                  rst_n;
    logic                  single_mode;
    logic                  delay_loop_disable_n;
    dsr_clk_type           clk_pins;
    dsr_cmd_type           cmd;
    logic [1:0]            phase;
    logic [DSR_DATA_W-1:0] dq_in;
    logic [DSR_DATA_W-1:0] dq_out;
    logic                  dq_oe;
    logic                  echo_clock;
    logic                  echo_clock_n;
    int                    n_mismatch = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    // =========================================================
    // Clock, partner, design
    always #5 clk_sys = ~clk_sys;

    dsr_ctrl_model ctrl (.clk_sys(clk_sys), .single_mode(single_mode),
                         .clk_pins(clk_pins), .phase(phase));

    dsr_sram_front uut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_pins(clk_pins), .cmd(cmd),
                        .delay_loop_disable_n(delay_loop_disable_n), .dq_in(dq_in),
                        .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(echo_clock),
                        .echo_clock_n(echo_clock_n));

    // =========================================================
    // Shared tasks
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DSR_DATA_W-1:0] got, input logic [DSR_DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ends on the falling edge at which the input clock rises
    task automatic sync;
        do @(posedge clk_sys); while (phase !== 2'h3);
        @(negedge clk_sys);
    endtask

    // Load strobe held for one whole input clock period
    task automatic issue(input logic rnw, input logic [DSR_ADDR_W-1:0] a);
        sync();
        cmd = '{1'b0, rnw, a};
        sync();
        cmd = '{1'b1, 1'b0, a};
    endtask

    task automatic do_reset(input logic single);
        single_mode = single;
        rst_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        check({16'h0, echo_clock, echo_clock_n}, 18'h00001);
        check({17'h0, dq_oe}, 18'h00000);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        $display("reset test done");
    endtask

    task automatic do_write(input logic [DSR_ADDR_W-1:0] a, input logic [DSR_DATA_W-1:0] w0,
                            input logic [DSR_DATA_W-1:0] w1);
        issue(1'b0, a);
        dq_in = w0;
        repeat (2) @(negedge clk_sys);
        dq_in = w1;
        repeat (2) @(negedge clk_sys);
        // Released data lines carry no stale copy of the last word
        dq_in = ~w1;
        $display("write test done");
    endtask

    task automatic do_read(input logic [DSR_ADDR_W-1:0] a, input logic [DSR_DATA_W-1:0] e0,
                           input logic [DSR_DATA_W-1:0] e1, input int lat);
        int n;
        issue(1'b1, a);
        n = 0;
        while (dq_oe !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        // Cycles from the strobe's release to the pins turning on: mode and delay loop set it
        check({17'h0, dq_oe}, 18'h00001);
        check(18'(n), 18'(lat));
        check(dq_out, e0);
        repeat (2) @(negedge clk_sys);
        check(dq_out, e1);
        repeat (8) @(negedge clk_sys);
        check({17'h0, dq_oe}, 18'h00000);
        $display("read test done");
    endtask

    task automatic t_echo;
        int   rises;
        logic prev;
        rises = 0;
        prev = echo_clock;
        repeat (16) begin
            @(negedge clk_sys);
            if (echo_clock === 1'b1 && prev === 1'b0) rises++;
            prev = echo_clock;
        end
        check(18'(rises), 18'h00004);
        check({17'h0, echo_clock ^ echo_clock_n}, 18'h00001);
        $display("echo clock test done");
    endtask

    // =========================================================
    // Hang guard, well above the some 170 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        single_mode = 1'b0;
        delay_loop_disable_n = 1'b1;
        cmd = '{1'b1, 1'b0, DSR_ADDR_RST};
        dq_in = DSR_DATA_RST;
        do_reset(1'b0);
        do_write(20'h00005, 18'h2a5a5, 18'h15a5a);
        do_read(20'h00005, 18'h2a5a5, 18'h15a5a, 6);
        do_read(20'h00004, 18'h15a5a, 18'h2a5a5, 6);
        t_echo();
        delay_loop_disable_n = 1'b0;
        do_read(20'h00005, 18'h2a5a5, 18'h15a5a, 7);
        delay_loop_disable_n = 1'b1;
        do_reset(1'b1);
        do_write(20'h0000b, 18'h3ffff, 18'h00001);
        do_read(20'h0000a, 18'h00001, 18'h3ffff, 2);
        t_echo();
        wrap_up();
    end
endmodule // test_dual_edge_sram_clock_access_pins
